// ### testbench.sv
`timescale 1ns/10ps
module testbench;
  import xbm_pkg::*;
  localparam logic [7:0] R_CNT = 8'h04, R_DST = 8'h08, R_SRC = 8'h0c, R_ACC = 8'h10;
  localparam logic [7:0] R_CNTA = 8'h14, R_DSTA = 8'h18, R_ACCA = 8'h20, R_STK = 8'h24;
  localparam logic [7:0] R_IDX1 = 8'h28, R_IDX2 = 8'h2c, R_PC = 8'h30, R_TST = 8'h34, R_MCY = 8'h38;
  logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'h0, lat = 4'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        mem_req, mem_we, mem_ack, busy;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata, mem_rdata;
  int          fails = 0;
  int          checks = 0;

  always #5 aclk = ~aclk;

  xbm_exec u_xbm_exec (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy));

  xbm_mem_model u_xbm_mem_model (.aclk(aclk), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic hang(input string what);
    fails++;
    $display("wrong value at %0t: %s never completed", $time, what);
    summarize();
  endtask : hang

  // handshakes are judged at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] resp);
    logic aw_t, w_t, b_t;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_wstrb   <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (int n = 0; n < 100; n++)
    begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t  = s_axi_wvalid && s_axi_wready;
      b_t  = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_t)
        s_axi_awvalid <= 1'b0;
      if (w_t)
        s_axi_wvalid <= 1'b0;
      if (b_t === 1'b1)
        return;
    end
    hang("write");
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_t, r_t;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 100; n++)
    begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t  = s_axi_rvalid;
      d    = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_t)
        s_axi_arvalid <= 1'b0;
      if (r_t === 1'b1)
        return;
    end
    hang("read");
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, exp, what);
  endtask : rchk

  task automatic wset(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
  endtask : wset

  task automatic idle();
    for (int n = 0; n < 2000; n++)
    begin
      @(negedge aclk);
      if (busy === 1'b0)
      begin
        @(posedge aclk);
        return;
      end
    end
    hang("instruction");
  endtask : idle

  // counters are cumulative, so only the difference per instruction is judged
  task automatic run(input logic [15:0] cmd, input logic [15:0] t, input logic [15:0] m);
    logic [31:0] t0, m0;
    logic [1:0]  r;
    rd(R_TST, t0, r);
    rd(R_MCY, m0, r);
    wset(OFF_CMD, cmd);
    idle();
    rchk(R_TST, t0 + t, "state count");
    rchk(R_MCY, m0 + m, "cycle count");
  endtask : run

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rchk(R_CNT, 32'h0000_0000, "counter after reset");
    rchk(R_STK, 32'h0000_0000, "stack pointer after reset");
    rd(8'h3c, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLV}, "unmapped read");
    wset(OFF_CMD, 16'h00ff);
    idle();
    rchk(OFF_CMD, 32'h0002_00ff, "illegal opcode flagged");
  endtask : t_reset

  task automatic t_exch();
    wset(R_DST, 16'h1234);
    wset(R_SRC, 16'h5678);
    wset(R_ACC, 16'ha5c3);
    wset(R_ACCA, 16'h0f00);
    run({PFX_NONE, OP_PTR_SWP}, 16'h0004, 16'h0001);
    rchk(R_DST, 32'h0000_5678, "target after swap");
    rchk(R_SRC, 32'h0000_1234, "source after swap");
    rchk(OFF_CMD, 32'h0000_00eb, "status after legal opcode");
    run({PFX_NONE, OP_ACC_SWP}, 16'h0004, 16'h0001);
    rchk(R_ACC, 32'h0000_0f00, "acc pair after swap");
    rchk(R_ACCA, 32'h0000_a5c3, "alternate acc pair");
    wset(R_CNT, 16'h0011);
    run({PFX_NONE, OP_BANK}, 16'h0004, 16'h0001);
    rchk(R_CNT, 32'h0000_0000, "counter after bank swap");
    rchk(R_CNTA, 32'h0000_0011, "alternate counter");
    rchk(R_DSTA, 32'h0000_5678, "alternate target");
    rchk(R_SRC, 32'h0000_0000, "source after bank swap");
    rchk(R_ACC, 32'h0000_0f00, "acc pair kept");
  endtask : t_exch

  task automatic t_stack();
    logic [7:0]  pf [3] = '{8'h00, 8'hdd, 8'hfd};
    logic [7:0]  rg [3] = '{R_SRC, R_IDX1, R_IDX2};
    logic [15:0] ts [3] = '{16'h0013, 16'h0017, 16'h0017};
    logic [15:0] ms [3] = '{16'h0005, 16'h0006, 16'h0006};
    for (int i = 0; i < 3; i++)
    begin
      lat <= i[3:0];
      u_xbm_mem_model.mem[8'h40] = 8'h11;
      u_xbm_mem_model.mem[8'h41] = 8'h22;
      wset(R_STK, 16'h0040);
      wset(rg[i], 16'habcd);
      run({pf[i], OP_STK}, ts[i], ms[i]);
      rchk(rg[i], 32'h0000_2211, "swapped register");
      chk({24'h0, u_xbm_mem_model.mem[8'h40]}, 32'h0000_00cd, "low byte at stack");
      chk({24'h0, u_xbm_mem_model.mem[8'h41]}, 32'h0000_00ab, "high byte at stack");
    end
  endtask : t_stack

  task automatic t_copy();
    logic [7:0] op [4] = '{8'ha0, 8'ha8, 8'hb0, 8'hb8};
    logic       up [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++)
    begin
      u_xbm_mem_model.mem[8'h10] = 8'h5a ^ i[7:0];
      wset(R_CNT, 16'h0001);
      wset(R_SRC, 16'h0010);
      wset(R_DST, 16'h0080);
      wset(R_ACC, 16'hffff);
      run({PFX_EXT, op[i]}, 16'h0010, 16'h0004);
      chk({24'h0, u_xbm_mem_model.mem[8'h80]}, {24'h0, 8'h5a ^ i[7:0]}, "copied byte");
      rchk(R_SRC, up[i] ? 32'h0000_0011 : 32'h0000_000f, "source pointer");
      rchk(R_DST, up[i] ? 32'h0000_0081 : 32'h0000_007f, "target pointer");
      rchk(R_CNT, 32'h0000_0000, "counter");
      rchk(R_ACC, 32'h0000_ffe9, "flags after copy");
    end
  endtask : t_copy

  task automatic t_rep();
    lat <= 4'h2;
    for (int j = 0; j < 3; j++)
      u_xbm_mem_model.mem[8'h20 + j[7:0]] = 8'h31 + j[7:0];
    wset(R_CNT, 16'h0003);
    wset(R_SRC, 16'h0020);
    wset(R_DST, 16'h0090);
    wset(R_ACC, 16'h0004);
    wset(R_PC, 16'h0100);
    run({PFX_EXT, 8'hb0}, 16'h003a, 16'h000e);
    rchk(R_PC, 32'h0000_00fc, "program counter rewound");
    for (int j = 0; j < 3; j++)
      chk({24'h0, u_xbm_mem_model.mem[8'h90 + j[7:0]]}, 32'h0000_0031 + j, "block copy");
    rchk(R_SRC, 32'h0000_0023, "source after block");
    rchk(R_ACC, 32'h0000_0000, "flags after block");
    wset(R_CNT, 16'h0002);
    wset(R_SRC, 16'h0022);
    wset(R_DST, 16'h00a1);
    run({PFX_EXT, 8'hb8}, 16'h0025, 16'h0009);
    chk({24'h0, u_xbm_mem_model.mem[8'ha0]}, 32'h0000_0032, "block copy down");
    rchk(R_DST, 32'h0000_009f, "target after block");
    wset(R_CNT, 16'h0002);
    run({PFX_EXT, 8'ha8}, 16'h0010, 16'h0004);
    rchk(R_ACC, 32'h0000_0004, "counter still non-zero");
  endtask : t_rep

  task automatic t_cmp();
    logic [7:0] op [4] = '{8'ha1, 8'ha9, 8'hb1, 8'hb9};
    logic       up [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    u_xbm_mem_model.mem[8'h30] = 8'h21;
    for (int i = 0; i < 4; i++)
    begin
      wset(R_CNT, 16'h0001);
      wset(R_SRC, 16'h0030);
      wset(R_ACC, 16'h1000);
      run({PFX_EXT, op[i]}, 16'h0010, 16'h0004);
      rchk(R_ACC, 32'h0000_1092, "flags no match");
      rchk(R_SRC, up[i] ? 32'h0000_0031 : 32'h0000_002f, "source pointer");
      rchk(R_CNT, 32'h0000_0000, "counter");
    end
    u_xbm_mem_model.mem[8'h30] = 8'h01;
    u_xbm_mem_model.mem[8'h31] = 8'h33;
    u_xbm_mem_model.mem[8'h32] = 8'h44;
    wset(R_CNT, 16'h0005);
    wset(R_SRC, 16'h0030);
    wset(R_ACC, 16'h3301);
    run({PFX_EXT, 8'hb1}, 16'h0025, 16'h0009);
    rchk(R_ACC, 32'h0000_3347, "flags on match");
    rchk(R_SRC, 32'h0000_0032, "stopped after match");
    rchk(R_CNT, 32'h0000_0003, "counter after match");
  endtask : t_cmp

  task automatic t_busy();
    logic [1:0] r;
    lat <= 4'h3;
    wset(R_CNT, 16'h0004);
    wset(R_SRC, 16'h0020);
    wset(R_DST, 16'h00b0);
    wset(OFF_CMD, {PFX_EXT, 8'hb0});
    wr(R_CNT, 16'h0009, r);
    chk({30'h0, r}, {30'h0, RESP_SLV}, "write while busy");
    idle();
    rchk(R_CNT, 32'h0000_0000, "counter ran out");
  endtask : t_busy

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_exch();
    t_stack();
    t_copy();
    t_rep();
    t_cmp();
    t_busy();
    summarize();
  end
endmodule : testbench

// ### xbm_exec.sv
`timescale 1ns/10ps
// Operation
// RQ1 - pointer pair swap and accumulator/flag alternate swap: 4 states, no flags
// RQ2 - bank swap exchanges counter and both pointers with alternates, 4 states
// RQ3 - stack top swap with source pointer: high at stack pointer plus one, 19 states
// RQ4 - stack top swap with either index register: same exchange, 23 states
// RQ5 - copy step up: copy byte, bump both pointers up, counter down, 16 states
// RQ6 - copy repeat up: repeat until counter zero; 21 states continuing, 16 last
// RQ7 - copy step down: copy byte, both pointers down, counter down, 16 states
// RQ8 - copy repeat down: repeat until counter zero; 21 continuing, 16 last
// RQ9 - compare step up: flags from acc minus byte, pointer up, counter down
// RQ10 - compare repeat up: repeat until match or counter zero; 21 or 16
// RQ11 - compare step down: flags only, pointer down, counter down, 16 states
// RQ12 - compare repeat down: repeat until match or counter zero; 21 or 16
// RQ13 - parity/overflow flag cleared when decremented counter is zero, else set
// RQ14 - match flag set when accumulator equals fetched byte, else cleared
// RQ15 - copies clear nibble carry and subtract, keep all but parity/overflow; exchanges keep all
// RQ16 - compares set subtract, update negative and nibble carry, keep carry
// RQ17 - continuing repeat steps program counter back two for refetch
module xbm_exec
  import xbm_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic               mem_req,
  output logic               mem_we,
  output logic [15:0]        mem_addr,
  output logic [7:0]         mem_wdata,
  input  wire logic          mem_ack,
  input  wire logic [7:0]    mem_rdata,
  output logic               busy
);
  import xbm_pkg::*;

  function automatic logic [4:0] reg_decode(input logic [7:0] a);
    logic [7:0] w;
    w = (a - OFF_REG0) >> 2;
    reg_decode = {(a[1:0] == 2'b00) && (a >= OFF_REG0) && (w < 8'(NREG)), w[3:0]};
  endfunction : reg_decode

  logic [15:0]  regs_q [NREG];
  xbm_state_t   state_q;
  logic [15:0]  opc_q;
  logic         step_q;
  logic         bad_q;
  logic [7:0]   buf_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic [7:0]   awaddr_q;
  logic         aw_have_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         w_have_q;
  logic         bvalid_q;
  logic [1:0]   bresp_q;
  logic         rvalid_q;
  logic [31:0]  rdata_q;
  logic [1:0]   rresp_q;

  // ---- decode of the held opcode
  wire  [7:0]   pfx      = opc_q[15:8];
  wire  [7:0]   op       = opc_q[7:0];
  wire          is_blk   = (pfx == PFX_EXT) && (op[7:5] == 3'b101) && (op[2:1] == 2'b00);
  wire          blk_rpt  = op[4];
  wire          blk_down = op[3];
  wire          blk_cmp  = op[0];
  wire          is_stk   = (op == OP_STK) && (pfx == PFX_NONE || pfx == PFX_XR1 || pfx == PFX_XR2);
  wire          stk_idx_sel = (pfx != PFX_NONE);
  wire  [3:0]   stk_idx  = (pfx == PFX_XR1) ? IDX_XR1 : (pfx == PFX_XR2) ? IDX_XR2 : IDX_SRC;
  wire          is_xch   = (pfx == PFX_NONE) && (op == OP_PTR_SWP || op == OP_ACC_SWP || op == OP_BANK);
  wire  [15:0]  stk_reg  = regs_q[stk_idx];
  wire  [15:0]  stk_addr = regs_q[IDX_STK] + {15'h0000, step_q};

  // ---- two-entry read buffer between the read and write halves
  wire          buf_in_ready = (cnt_q != 2'd2);
  wire          buf_out_valid = (cnt_q != 2'd0);
  wire  [7:0]   head     = buf_q[rp_q];
  wire  [7:0]   nxt      = buf_q[~rp_q];
  wire          push     = (state_q == S_RD) && mem_ack && buf_in_ready;
  wire          pop      = (state_q == S_EXE) && buf_out_valid;

  // ---- block arithmetic
  wire  [7:0]   acc      = regs_q[IDX_ACC][15:8];
  wire  [7:0]   fl       = regs_q[IDX_ACC][7:0];
  wire  [15:0]  ctr_next = regs_q[IDX_CNT] - 16'h0001;
  wire          ctr_nz   = (ctr_next != 16'h0000);
  wire  [7:0]   diff     = acc - head;
  wire          match    = (acc == head);
  wire          hborrow  = (acc[3:0] < head[3:0]);
  wire  [15:0]  delta    = blk_down ? 16'hffff : 16'h0001;
  wire          cont     = blk_rpt && ctr_nz && !(blk_cmp && match); // [RQ6] [RQ8] [RQ10] [RQ12]
  wire  [15:0]  t_add    = cont ? T_BLK_RPT : T_BLK_LAST;
  wire  [15:0]  m_add    = cont ? M_BLK_RPT : M_BLK_LAST;
  wire  [7:0]   fl_copy  = {fl[7:5], 1'b0, fl[3], ctr_nz, 1'b0, fl[0]}; // [RQ13] [RQ15]
  wire  [7:0]   fl_cmp   = {diff[7], match, fl[5], hborrow, fl[3], ctr_nz, 1'b1, fl[0]}; // [RQ14] [RQ16]
  wire  [7:0]   fl_blk   = blk_cmp ? fl_cmp : fl_copy;

  // ---- memory port, request held until acknowledged
  assign mem_req   = ((state_q == S_RD) && buf_in_ready) || (state_q == S_WR);
  assign mem_we    = (state_q == S_WR);
  assign mem_addr  = (state_q == S_WR) ? (is_stk ? stk_addr : regs_q[IDX_DST])
                                       : (is_stk ? stk_addr : regs_q[IDX_SRC]); // [RQ3] [RQ4]
  assign mem_wdata = is_stk ? (step_q ? stk_reg[15:8] : stk_reg[7:0]) : head;
  assign busy      = (state_q != S_IDLE);

  // ---- bus decode
  wire          wr_go    = aw_have_q && w_have_q && !bvalid_q;
  wire  [4:0]   wdec     = reg_decode(awaddr_q);
  wire  [4:0]   rdec     = reg_decode(s_axi_araddr);
  wire          wr_cmd   = wr_go && (awaddr_q == OFF_CMD);
  wire          wr_reg   = wr_go && wdec[4] && !busy;
  wire          wr_ok    = (wr_cmd || wdec[4]) && !busy;
  wire  [15:0]  old_w    = regs_q[wdec[3:0]];
  wire  [15:0]  merged   = {wstrb_q[1] ? wdata_q[15:8] : old_w[15:8], wstrb_q[0] ? wdata_q[7:0] : old_w[7:0]};
  wire          start    = wr_cmd && !busy;
  wire  [31:0]  status   = {14'h0000, bad_q, busy, opc_q};
  wire  [31:0]  rd_word  = (s_axi_araddr == OFF_CMD) ? status : {16'h0000, regs_q[rdec[3:0]]};
  wire          rd_hit   = (s_axi_araddr == OFF_CMD) || rdec[4];

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready  = !w_have_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        // busy refuses every write so a running instruction sees stable registers
        bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLV;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_hit ? rd_word : 32'h0000_0000;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLV;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 2'd0;
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      buf_q <= '{8'h00, 8'h00};
    end
    else
    begin
      if (push)
      begin
        buf_q[wp_q] <= mem_rdata;
        wp_q        <= ~wp_q;
      end
      // stack swaps drain both bytes at once
      if (pop)
        rp_q <= is_stk ? rp_q : ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - (pop ? (is_stk ? 2'd2 : 2'd1) : 2'd0);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= S_IDLE;
      opc_q   <= 16'h0000;
      step_q  <= 1'b0;
      bad_q   <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_IDLE:
          if (start)
          begin
            opc_q   <= wdata_q[15:0];
            state_q <= S_DEC;
          end
        S_DEC:
        begin
          step_q  <= 1'b0;
          bad_q   <= !(is_xch || is_stk || is_blk);
          state_q <= (is_stk || is_blk) ? S_RD : S_IDLE;
        end
        S_RD:
          if (push)
          begin
            step_q  <= is_stk && !step_q;
            state_q <= (is_stk && !step_q) ? S_RD : (blk_cmp && !is_stk) ? S_EXE : S_WR;
          end
        S_WR:
          if (mem_ack)
          begin
            step_q  <= is_stk && !step_q;
            state_q <= (is_stk && !step_q) ? S_WR : S_EXE;
          end
        S_EXE:
          state_q <= (is_blk && cont) ? S_RD : S_IDLE; // [RQ17]
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NREG; i++)
        regs_q[i] <= REG_RST;
    end
    else
    begin
      if (wr_reg)
        regs_q[wdec[3:0]] <= merged;
      if (state_q == S_DEC && is_xch)
      begin
        regs_q[IDX_TST] <= regs_q[IDX_TST] + T_XCH; // [RQ1] [RQ2]
        regs_q[IDX_MCY] <= regs_q[IDX_MCY] + M_XCH;
        if (op == OP_PTR_SWP)
        begin
          regs_q[IDX_DST] <= regs_q[IDX_SRC]; // [RQ1]
          regs_q[IDX_SRC] <= regs_q[IDX_DST];
        end
        if (op == OP_ACC_SWP)
        begin
          regs_q[IDX_ACC]     <= regs_q[IDX_ACC_ALT]; // [RQ1] [RQ15]
          regs_q[IDX_ACC_ALT] <= regs_q[IDX_ACC];
        end
        if (op == OP_BANK)
        begin
          for (int i = 0; i < 3; i++)
          begin
            regs_q[i]     <= regs_q[i + 4]; // [RQ2]
            regs_q[i + 4] <= regs_q[i];
          end
        end
      end
      if (state_q == S_EXE && is_stk)
      begin
        regs_q[stk_idx] <= {nxt, head}; // [RQ3] [RQ4]
        regs_q[IDX_TST] <= regs_q[IDX_TST] + (stk_idx_sel ? T_STK_IDX : T_STK_PTR);
        regs_q[IDX_MCY] <= regs_q[IDX_MCY] + (stk_idx_sel ? M_STK_IDX : M_STK_PTR);
      end
      if (state_q == S_EXE && is_blk)
      begin
        regs_q[IDX_SRC] <= regs_q[IDX_SRC] + delta; // [RQ5] [RQ7] [RQ9] [RQ11]
        if (!blk_cmp)
          regs_q[IDX_DST] <= regs_q[IDX_DST] + delta;
        regs_q[IDX_CNT] <= ctr_next;
        regs_q[IDX_ACC] <= {acc, fl_blk};
        regs_q[IDX_TST] <= regs_q[IDX_TST] + t_add;
        regs_q[IDX_MCY] <= regs_q[IDX_MCY] + m_add;
        if (cont)
          regs_q[IDX_PC] <= regs_q[IDX_PC] - PC_REWIND; // [RQ17]
      end
    end
  end

  wire ex_blk = (state_q == S_EXE) && is_blk;

  property p_ptr_swap;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == S_DEC && pfx == PFX_NONE && op == OP_PTR_SWP)
      |=> regs_q[IDX_DST] == $past(regs_q[IDX_SRC]) && regs_q[IDX_SRC] == $past(regs_q[IDX_DST])
          && regs_q[IDX_ACC] == $past(regs_q[IDX_ACC]) && state_q == S_IDLE;
  endproperty
  a_ptr_swap: assert property (p_ptr_swap) else $error("pointer swap wrong"); // [RQ1]

  property p_bank;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == S_DEC && pfx == PFX_NONE && op == OP_BANK)
      |=> regs_q[IDX_CNT] == $past(regs_q[IDX_CNT_ALT]) && regs_q[IDX_SRC_ALT] == $past(regs_q[IDX_SRC])
          && regs_q[IDX_TST] == $past(regs_q[IDX_TST]) + T_XCH;
  endproperty
  a_bank: assert property (p_bank) else $error("bank swap wrong"); // [RQ2]

  property p_stk_ptr;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == S_EXE && is_stk && !stk_idx_sel)
      |=> regs_q[IDX_MCY] == $past(regs_q[IDX_MCY]) + M_STK_PTR && regs_q[IDX_SRC] == {$past(nxt), $past(head)};
  endproperty
  a_stk_ptr: assert property (p_stk_ptr) else $error("stack swap with pointer wrong"); // [RQ3]

  property p_stk_idx;
    @(posedge aclk) disable iff (!aresetn)
    (state_q == S_EXE && is_stk && stk_idx_sel) |=> regs_q[IDX_TST] == $past(regs_q[IDX_TST]) + T_STK_IDX;
  endproperty
  a_stk_idx: assert property (p_stk_idx) else $error("index stack swap timing wrong"); // [RQ4]

  property p_copy_up;
    @(posedge aclk) disable iff (!aresetn)
    (ex_blk && !blk_cmp && !blk_down)
      |=> regs_q[IDX_DST] == $past(regs_q[IDX_DST]) + 16'h0001
          && regs_q[IDX_CNT] == $past(regs_q[IDX_CNT]) - 16'h0001;
  endproperty
  a_copy_up: assert property (p_copy_up) else $error("copy step pointers wrong"); // [RQ5]

  property p_rewind;
    @(posedge aclk) disable iff (!aresetn)
    (ex_blk && cont) |=> regs_q[IDX_PC] == $past(regs_q[IDX_PC]) - PC_REWIND && state_q == S_RD
                         && regs_q[IDX_TST] == $past(regs_q[IDX_TST]) + T_BLK_RPT;
  endproperty
  a_rewind: assert property (p_rewind) else $error("repeat did not rewind"); // [RQ17]

  property p_pv;
    @(posedge aclk) disable iff (!aresetn)
    ex_blk |=> regs_q[IDX_ACC][FL_PV] == (regs_q[IDX_CNT] != 16'h0000);
  endproperty
  a_pv: assert property (p_pv) else $error("parity flag wrong"); // [RQ13]

  property p_match;
    @(posedge aclk) disable iff (!aresetn)
    (ex_blk && blk_cmp) |=> regs_q[IDX_ACC][FL_Z] == $past(match) && regs_q[IDX_ACC][FL_N]
                            && regs_q[IDX_ACC][FL_C] == $past(fl[FL_C]);
  endproperty
  a_match: assert property (p_match) else $error("compare flags wrong"); // [RQ14]

  property p_copy_fl;
    @(posedge aclk) disable iff (!aresetn)
    (ex_blk && !blk_cmp) |=> !regs_q[IDX_ACC][FL_H] && !regs_q[IDX_ACC][FL_N]
                             && regs_q[IDX_ACC][FL_Z] == $past(fl[FL_Z]);
  endproperty
  a_copy_fl: assert property (p_copy_fl) else $error("copy flags wrong"); // [RQ15]

endmodule : xbm_exec

// ### xbm_mem_model.sv
`timescale 1ns/10ps
module xbm_mem_model (
  input  wire logic        aclk,
  input  wire logic [3:0]  lat,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_ack,
  output logic [7:0]       mem_rdata
);
  logic [7:0] mem [256];
  logic [3:0] cnt_q;
  logic [7:0] rd_q;

  // outside an ack the bus shows the inverse, so a late sample is caught
  assign mem_rdata = mem_ack ? rd_q : ~rd_q;

  initial
  begin
    mem_ack = 1'b0;
    cnt_q   = 4'h0;
    rd_q    = 8'h00;
  end

  // only the low address byte is decoded; tests stay below 8'hff
  always @(posedge aclk)
  begin
    if (!mem_req || mem_ack)
    begin
      mem_ack <= 1'b0;
      cnt_q   <= 4'h0;
    end
    else if (cnt_q >= lat)
    begin
      mem_ack <= 1'b1;
      rd_q    <= mem[mem_addr[7:0]];
      if (mem_we)
        mem[mem_addr[7:0]] <= mem_wdata;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule : xbm_mem_model

// ### xbm_pkg.sv
package xbm_pkg;

  localparam int          NREG       = 14;
  localparam int          AW         = 8;

  localparam logic [7:0]  OFF_CMD    = 8'h00;
  localparam logic [7:0]  OFF_REG0   = 8'h04;

  localparam logic [3:0]  IDX_CNT     = 4'h0;
  localparam logic [3:0]  IDX_DST     = 4'h1;
  localparam logic [3:0]  IDX_SRC     = 4'h2;
  localparam logic [3:0]  IDX_ACC     = 4'h3;
  localparam logic [3:0]  IDX_CNT_ALT = 4'h4;
  localparam logic [3:0]  IDX_DST_ALT = 4'h5;
  localparam logic [3:0]  IDX_SRC_ALT = 4'h6;
  localparam logic [3:0]  IDX_ACC_ALT = 4'h7;
  localparam logic [3:0]  IDX_STK     = 4'h8;
  localparam logic [3:0]  IDX_XR1     = 4'h9;
  localparam logic [3:0]  IDX_XR2     = 4'ha;
  localparam logic [3:0]  IDX_PC      = 4'hb;
  localparam logic [3:0]  IDX_TST     = 4'hc;
  localparam logic [3:0]  IDX_MCY     = 4'hd;
  localparam logic [15:0] REG_RST     = 16'h0000;

  localparam logic [7:0]  PFX_NONE   = 8'h00;
  localparam logic [7:0]  PFX_EXT    = 8'hed;
  localparam logic [7:0]  PFX_XR1    = 8'hdd;
  localparam logic [7:0]  PFX_XR2    = 8'hfd;
  localparam logic [7:0]  OP_PTR_SWP = 8'heb;
  localparam logic [7:0]  OP_ACC_SWP = 8'h08;
  localparam logic [7:0]  OP_BANK    = 8'hd9;
  localparam logic [7:0]  OP_STK     = 8'he3;

  localparam int          FL_C       = 0;
  localparam int          FL_N       = 1;
  localparam int          FL_PV      = 2;
  localparam int          FL_H       = 4;
  localparam int          FL_Z       = 6;
  localparam int          FL_S       = 7;

  localparam logic [15:0] T_XCH      = 16'h0004;
  localparam logic [15:0] M_XCH      = 16'h0001;
  localparam logic [15:0] T_STK_PTR  = 16'h0013;
  localparam logic [15:0] M_STK_PTR  = 16'h0005;
  localparam logic [15:0] T_STK_IDX  = 16'h0017;
  localparam logic [15:0] M_STK_IDX  = 16'h0006;
  localparam logic [15:0] T_BLK_LAST = 16'h0010;
  localparam logic [15:0] M_BLK_LAST = 16'h0004;
  localparam logic [15:0] T_BLK_RPT  = 16'h0015;
  localparam logic [15:0] M_BLK_RPT  = 16'h0005;
  localparam logic [15:0] PC_REWIND  = 16'h0002;

  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLV   = 2'b10;
  localparam int          ST_BUSY    = 16;
  localparam int          ST_BAD     = 17;

  typedef enum logic [2:0] {S_IDLE, S_DEC, S_RD, S_WR, S_EXE} xbm_state_t;

endpackage : xbm_pkg
